// [gpr_pkg.sv]
/*
  Constants for the gigabit PHY control/status register group.
  Assumes a 16-bit management register space indexed by register number.
*/
`default_nettype none

package gpr_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned EXT_ADDR_W = 9;

  localparam logic [4:0] OFF_GB_CTRL = 5'h09;
  localparam logic [4:0] OFF_GB_STAT = 5'h0A;
  localparam logic [4:0] OFF_EXT_CTRL = 5'h0B;
  localparam logic [4:0] OFF_EXT_WDATA = 5'h0C;
  localparam logic [4:0] OFF_EXT_RDATA = 5'h0D;

  localparam int unsigned CTRL_TEST_HI = 15;
  localparam int unsigned CTRL_TEST_LO = 13;
  localparam int unsigned CTRL_MAN_EN = 12;
  localparam int unsigned CTRL_MAN_VAL = 11;
  localparam int unsigned CTRL_PORT_TYPE = 10;
  localparam int unsigned CTRL_ADV_FD = 9;
  localparam int unsigned CTRL_ADV_HD = 8;

  localparam int unsigned EXT_DIR_BIT = 15;
  localparam int unsigned EXT_RSVD_HI = 14;
  localparam int unsigned EXT_RSVD_LO = 9;
  localparam int unsigned EXT_PAGE_BIT = 8;

  localparam logic [2:0] TEST_RST = 3'h0;
  localparam logic ADV_FD_RST = 1'b1;
  localparam logic [15:0] EXT_CTRL_RST = 16'h0000;
  localparam logic [15:0] EXT_WDATA_RST = 16'h0000;
  localparam logic [15:0] EXT_RDATA_RST = 16'h0000;
  localparam logic [7:0] IDLE_ERR_RST = 8'h00;

  typedef enum logic [2:0] {
    GPR_TEST_NORMAL,
    GPR_TEST_WAVEFORM,
    GPR_TEST_JITTER_MASTER,
    GPR_TEST_JITTER_SLAVE,
    GPR_TEST_DISTORTION
  } gpr_test_mode_t;

endpackage : gpr_pkg

`default_nettype wire

// [gpr_regs.sv]
/*
  Gigabit control/status registers with indirect extended-register access.
  Assumes a synchronous host port and status inputs on clk; the extended
  register array lives outside and answers on the cycle it is strobed.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none


module gpr_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [gpr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gpr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [gpr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic strap_adv_half,
  input wire logic role_fault,
  input wire logic role_is_master,
  input wire logic loc_rcvr_ok,
  input wire logic rem_rcvr_ok,
  input wire logic partner_gigabit_full_capable,
  input wire logic partner_gigabit_half_capable,
  input wire logic symbol_tick,
  input wire logic idle_rx_send_n,
  input wire logic rx_error,
  output gpr_pkg::gpr_test_mode_t test_mode,
  output logic role_force_valid,
  output logic role_force_master,
  output logic role_prefer_master,
  output logic adv_gigabit_full,
  output logic adv_gigabit_half,
  output logic ext_stb,
  output logic ext_write,
  output logic [gpr_pkg::EXT_ADDR_W-1:0] ext_addr,
  output logic [gpr_pkg::DATA_W-1:0] ext_wdata,
  input wire logic [gpr_pkg::DATA_W-1:0] ext_rdata
);
  import gpr_pkg::*;

  // ****************************************
  // register state
  // ****************************************
  logic [2:0] test_q;
  logic man_en_q;
  logic man_val_q;
  logic port_type_q;
  logic adv_fd_q;
  logic adv_hd_q;
  logic strap_done_q;
  logic fault_q;
  logic [7:0] idle_err_q;
  logic [15:0] ext_ctrl_q;
  logic [15:0] ext_wdata_q;
  logic [15:0] ext_rdata_q;
  logic ext_stb_q;
  logic [15:0] rdata_q;

  // ****************************************
  // decode
  // ****************************************
  // strobe qualified by one register number
  function automatic logic bus_hit(input logic stb,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    return stb && (addr == off);
  endfunction : bus_hit

  wire wr_ctrl = bus_hit(reg_wr, reg_addr, OFF_GB_CTRL);
  wire wr_ext_ctrl = bus_hit(reg_wr, reg_addr, OFF_EXT_CTRL);
  wire wr_ext_wdata = bus_hit(reg_wr, reg_addr, OFF_EXT_WDATA);
  wire rd_stat = bus_hit(reg_rd, reg_addr, OFF_GB_STAT);
  wire rd_ext_ctrl = bus_hit(reg_rd, reg_addr, OFF_EXT_CTRL);
  wire rd_ext_rdata = bus_hit(reg_rd, reg_addr, OFF_EXT_RDATA);
  wire idle_err_hit = symbol_tick && idle_rx_send_n && rx_error;
  wire idle_err_sat = (idle_err_q == 8'hFF);

  wire [15:0] ctrl_view = {test_q, man_en_q, man_val_q, port_type_q,
                           adv_fd_q, adv_hd_q, 8'h00};
  wire [15:0] stat_view = {fault_q, role_is_master, loc_rcvr_ok,
                           rem_rcvr_ok, partner_gigabit_full_capable,
                           partner_gigabit_half_capable, 2'b00,
                           idle_err_q};
  // reserved control bits 14:9 stored as written
  wire [15:0] ext_ctrl_d = reg_wdata;

  logic [15:0] rdata_d;
  always_comb begin
    rdata_d = 16'h0000;
    unique case (reg_addr)
      OFF_GB_CTRL: rdata_d = ctrl_view;
      OFF_GB_STAT: rdata_d = stat_view;
      OFF_EXT_CTRL: rdata_d = ext_ctrl_q;
      OFF_EXT_WDATA: rdata_d = ext_wdata_q;
      OFF_EXT_RDATA: rdata_d = ext_rdata_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // ****************************************
  // gigabit control
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      test_q <= TEST_RST;
      man_en_q <= 1'b0;
      man_val_q <= 1'b0;
      port_type_q <= 1'b0;
      adv_fd_q <= ADV_FD_RST;
    end else if (wr_ctrl) begin
      test_q <= reg_wdata[CTRL_TEST_HI:CTRL_TEST_LO];
      man_en_q <= reg_wdata[CTRL_MAN_EN];
      man_val_q <= reg_wdata[CTRL_MAN_VAL];
      port_type_q <= reg_wdata[CTRL_PORT_TYPE];
      adv_fd_q <= reg_wdata[CTRL_ADV_FD];
    end
  end

  // strap sampled by the first clock after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_hd_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        adv_hd_q <= strap_adv_half;
      end else if (wr_ctrl) begin
        adv_hd_q <= reg_wdata[CTRL_ADV_HD];
      end
    end
  end

  // ****************************************
  // gigabit status
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_q <= 1'b0;
    end else if (role_fault) begin
      fault_q <= 1'b1;
    end else if (rd_stat) begin
      fault_q <= 1'b0;
    end
  end

  // saturating count; new error on the read cycle restarts at one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_err_q <= IDLE_ERR_RST;
    end else if (rd_stat) begin
      idle_err_q <= {7'h00, idle_err_hit};
    end else if (idle_err_hit && !idle_err_sat) begin
      idle_err_q <= idle_err_q + 8'h01;
    end
  end

  // ****************************************
  // extended register window
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_ctrl_q <= EXT_CTRL_RST;
      ext_wdata_q <= EXT_WDATA_RST;
      ext_stb_q <= 1'b0;
    end else begin
      ext_stb_q <= wr_ext_ctrl;
      if (wr_ext_ctrl) begin
        ext_ctrl_q <= ext_ctrl_d;
      end
      if (wr_ext_wdata) begin
        ext_wdata_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_rdata_q <= EXT_RDATA_RST;
    end else if (ext_stb_q && !ext_ctrl_q[EXT_DIR_BIT]) begin
      ext_rdata_q <= ext_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = rdata_q;
  assign test_mode = gpr_test_mode_t'(test_q);
  assign role_force_valid = man_en_q;
  assign role_force_master = man_en_q && man_val_q;
  assign role_prefer_master = !man_en_q && port_type_q;
  assign adv_gigabit_full = adv_fd_q;
  assign adv_gigabit_half = adv_hd_q;
  assign ext_stb = ext_stb_q;
  assign ext_write = ext_ctrl_q[EXT_DIR_BIT];
  assign ext_addr = ext_ctrl_q[EXT_PAGE_BIT:0];
  assign ext_wdata = ext_wdata_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_fault_latch: assert property (
    role_fault |=> fault_q)
    else $error("role fault not latched");
  chk_fault_clear: assert property (
    rd_stat && !role_fault |=> !fault_q)
    else $error("role fault not cleared by read");
  chk_err_count: assert property (
    !rd_stat && idle_err_hit && !idle_err_sat
      |=> idle_err_q == $past(idle_err_q) + 8'h01)
    else $error("idle error count missed a step");
  chk_err_hold: assert property (
    !rd_stat && !idle_err_hit |=> $stable(idle_err_q))
    else $error("idle error count moved without error");
  chk_err_rdclr: assert property (
    rd_stat && !idle_err_hit |=> idle_err_q == 8'h00)
    else $error("idle error count not cleared");
  chk_role_ignore: assert property (
    !man_en_q |-> !role_force_master && !role_force_valid)
    else $error("manual role used while disabled");
  chk_role_force: assert property (
    wr_ctrl && reg_wdata[CTRL_MAN_EN]
      |=> role_force_master == $past(reg_wdata[CTRL_MAN_VAL]))
    else $error("manual role not applied");
  chk_port_pref: assert property (
    wr_ctrl |=> role_prefer_master ==
      (!$past(reg_wdata[CTRL_MAN_EN]) && $past(reg_wdata[CTRL_PORT_TYPE])))
    else $error("port preference wrong");
  chk_ext_read: assert property (
    wr_ext_ctrl && !reg_wdata[EXT_DIR_BIT]
      ##1 1 ##1 reg_rd && reg_addr == OFF_EXT_RDATA
      |=> reg_rdata == $past(ext_rdata, 2))
    else $error("extended read data wrong");
  chk_ext_stb: assert property (
    wr_ext_ctrl |=> ext_stb ##1 !ext_stb || $past(wr_ext_ctrl))
    else $error("extended strobe wrong");
  chk_stat_view: assert property (
    reg_rd && reg_addr == OFF_GB_STAT
      |=> reg_rdata[13] == $past(loc_rcvr_ok)
        && reg_rdata[12] == $past(rem_rcvr_ok))
    else $error("receiver status not mirrored");

  // ****************************************
  // checks on the control register
  // ****************************************
  chk_test_mode: assert property (
    wr_ctrl |=> 3'(test_mode) ==
      $past(reg_wdata[CTRL_TEST_HI:CTRL_TEST_LO]))
    else $error("test mode not applied");
  chk_test_hold: assert property (
    !wr_ctrl |=> $stable(test_mode))
    else $error("test mode moved without write");
  chk_role_hold: assert property (
    !wr_ctrl |=> $stable(role_force_master)
      && $stable(role_force_valid))
    else $error("manual role moved without write");
  chk_pref_hold: assert property (
    !wr_ctrl |=> $stable(role_prefer_master))
    else $error("port preference moved without write");
  chk_adv_full: assert property (
    wr_ctrl |=> adv_gigabit_full == $past(reg_wdata[CTRL_ADV_FD]))
    else $error("full-duplex advert not applied");
  chk_adv_fd_hold: assert property (
    !wr_ctrl |=> $stable(adv_gigabit_full))
    else $error("full-duplex advert moved without write");
  chk_strap_load: assert property (
    rst_b && !strap_done_q |=> adv_gigabit_half == $past(strap_adv_half))
    else $error("half-duplex strap not loaded");
  chk_adv_half: assert property (
    wr_ctrl && strap_done_q
      |=> adv_gigabit_half == $past(reg_wdata[CTRL_ADV_HD]))
    else $error("half-duplex advert not applied");

  // ****************************************
  // checks on the status register
  // ****************************************
  chk_stat_role: assert property (
    rd_stat |=> reg_rdata[14] == $past(role_is_master))
    else $error("resolved role not reported");
  chk_stat_partner: assert property (
    rd_stat |=> reg_rdata[11:10] ==
      $past({partner_gigabit_full_capable, partner_gigabit_half_capable}))
    else $error("partner abilities not reported");
  chk_stat_rsvd: assert property (
    rd_stat |=> reg_rdata[9:8] == 2'b00)
    else $error("reserved status bits not zero");
  chk_fault_read: assert property (
    rd_stat |=> reg_rdata[15] == $past(fault_q))
    else $error("role fault not reported");
  chk_fault_hold: assert property (
    !role_fault && !rd_stat |=> $stable(fault_q))
    else $error("role fault moved without cause");
  chk_count_read: assert property (
    rd_stat |=> reg_rdata[7:0] == $past(idle_err_q))
    else $error("idle error count not reported");
  chk_err_read_hit: assert property (
    rd_stat && idle_err_hit |=> idle_err_q == 8'h01)
    else $error("error on clearing read lost");
  chk_err_sat: assert property (
    idle_err_sat && !rd_stat |=> idle_err_sat)
    else $error("idle error count wrapped");

  // ****************************************
  // checks on the extended window
  // ****************************************
  chk_ext_write: assert property (
    wr_ext_ctrl |=> ext_write == $past(reg_wdata[EXT_DIR_BIT]))
    else $error("extended direction not applied");
  chk_ext_addr: assert property (
    wr_ext_ctrl |=> ext_addr == $past(reg_wdata[EXT_PAGE_BIT:0]))
    else $error("extended page or address not applied");
  chk_ext_ctrl_hold: assert property (
    !wr_ext_ctrl |=> $stable(ext_addr) && $stable(ext_write))
    else $error("extended control moved without write");
  chk_ext_ctrl_read: assert property (
    wr_ext_ctrl ##1 rd_ext_ctrl
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("extended control not read back");
  chk_ext_wdata: assert property (
    wr_ext_wdata |=> ext_wdata == $past(reg_wdata))
    else $error("extended write data not applied");
  chk_wdata_hold: assert property (
    !wr_ext_wdata |=> $stable(ext_wdata))
    else $error("extended write data moved without write");
  chk_ext_capture: assert property (
    ext_stb && !ext_write |=> ext_rdata_q == $past(ext_rdata))
    else $error("extended read data not captured");
  chk_ext_keep: assert property (
    !(ext_stb && !ext_write) |=> $stable(ext_rdata_q))
    else $error("extended read data moved without read");
  chk_rdata_map: assert property (
    rd_ext_rdata |=> reg_rdata == $past(ext_rdata_q))
    else $error("read-data register not returned");
  chk_stb_cause: assert property (
    ext_stb |-> $past(wr_ext_ctrl))
    else $error("extended strobe without control write");

  cov_ext_write: cover property (wr_ext_ctrl && reg_wdata[EXT_DIR_BIT]);
  cov_ext_read: cover property (wr_ext_ctrl && !reg_wdata[EXT_DIR_BIT]);
  cov_fault_read: cover property (fault_q && rd_stat);
  cov_err_sat: cover property (idle_err_sat);
  cov_read_hit: cover property (rd_stat && idle_err_hit);

endmodule : gpr_regs

`default_nettype wire

// [gpr_ext_model.sv]
/*
  Behavioural extended register array behind the indirect window.
  Assumes one clock shared with gpr_regs and a strobe of one cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module gpr_ext_model (
  input wire logic clk,
  input wire logic ext_stb,
  input wire logic ext_write,
  input wire logic [gpr_pkg::EXT_ADDR_W-1:0] ext_addr,
  input wire logic [gpr_pkg::DATA_W-1:0] ext_wdata,
  output logic [gpr_pkg::DATA_W-1:0] ext_rdata
);
  import gpr_pkg::*;
  logic [DATA_W-1:0] mem_q [2**EXT_ADDR_W];

  initial begin
    for (int i = 0; i < 2**EXT_ADDR_W; i++) begin
      mem_q[i] = 16'h0000;
    end
  end

  // page and address pick the word, direction picks write
  always @(posedge clk) begin
    if (ext_stb && ext_write) begin
      mem_q[ext_addr] <= ext_wdata;
    end
  end

  // outside the strobe the bus shows the inverted word, never a stale copy
  assign ext_rdata = ext_stb ? mem_q[ext_addr] : ~mem_q[ext_addr];
endmodule : gpr_ext_model

`default_nettype wire

// [gpr_regs_tb_top.sv]
/*
  Self-checking bench for gpr_regs over its register port.
  Assumes gpr_pkg and gpr_ext_model compiled before this file.
*/
`timescale 1ns/1ns
`default_nettype none

module gpr_regs_tb_top;
  import gpr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, strap_adv_half = 1'b1;
  logic role_fault = 1'b0, role_is_master = 1'b0, loc_rcvr_ok = 1'b0;
  logic rem_rcvr_ok = 1'b0, symbol_tick = 1'b0, idle_rx_send_n = 1'b0;
  logic partner_gigabit_full_capable = 1'b0, rx_error = 1'b0;
  logic partner_gigabit_half_capable = 1'b0;
  logic [DATA_W-1:0] reg_rdata, ext_wdata, ext_rdata;
  gpr_test_mode_t test_mode;
  logic role_force_valid, role_force_master, role_prefer_master;
  logic adv_gigabit_full, adv_gigabit_half, ext_stb, ext_write;
  logic [EXT_ADDR_W-1:0] ext_addr;
  int miscompares = 0;
  int tests_run = 0;

  always #5 clk = ~clk;

  gpr_regs dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .strap_adv_half, .role_fault, .role_is_master,
    .loc_rcvr_ok, .rem_rcvr_ok, .partner_gigabit_full_capable,
    .partner_gigabit_half_capable, .symbol_tick, .idle_rx_send_n,
    .rx_error, .test_mode, .role_force_valid, .role_force_master,
    .role_prefer_master, .adv_gigabit_full, .adv_gigabit_half, .ext_stb,
    .ext_write, .ext_addr, .ext_wdata, .ext_rdata);

  gpr_ext_model ext_model (.clk, .ext_stb, .ext_write, .ext_addr,
    .ext_wdata, .ext_rdata);

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      symbol_tick <= 1'b1;
      @(posedge clk);
      symbol_tick <= 1'b0;
    end
  endtask : tick

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    miscompares++;
    end_sim;
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk(16'(adv_gigabit_full), 16'h0001);
    chk(16'(adv_gigabit_half), 16'h0001);
    rd(OFF_GB_CTRL, 16'h0300);
    rd(OFF_GB_STAT, 16'h0000);
    rd(OFF_EXT_CTRL, EXT_CTRL_RST);
    rd(OFF_EXT_WDATA, EXT_WDATA_RST);
    rd(OFF_EXT_RDATA, EXT_RDATA_RST);
    rd(5'h00, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(OFF_GB_CTRL, {i[2:0], 13'h0000});
      @(negedge clk);
      chk(16'(test_mode), 16'(i));
      rd(OFF_GB_CTRL, {i[2:0], 13'h0000});
    end
    chk(16'(adv_gigabit_full), 16'h0000);
    chk(16'(adv_gigabit_half), 16'h0000);
    $display("test modes done");
    wr(OFF_GB_CTRL, 16'h1C00);
    @(negedge clk);
    chk(16'({role_force_valid, role_force_master, role_prefer_master}),
      16'h0006);
    wr(OFF_GB_CTRL, 16'h0C00);
    @(negedge clk);
    chk(16'({role_force_valid, role_force_master, role_prefer_master}),
      16'h0001);
    wr(OFF_GB_CTRL, 16'h1000);
    @(negedge clk);
    chk(16'({role_force_valid, role_force_master}), 16'h0002);
    $display("test role done");
    @(posedge clk);
    {role_is_master, loc_rcvr_ok, rem_rcvr_ok, partner_gigabit_full_capable,
      partner_gigabit_half_capable} <= 5'h1F;
    rd(OFF_GB_STAT, 16'h7C00);
    @(posedge clk);
    {role_is_master, loc_rcvr_ok, rem_rcvr_ok, partner_gigabit_full_capable,
      partner_gigabit_half_capable} <= 5'h0A;
    role_fault <= 1'b1;
    @(posedge clk);
    role_fault <= 1'b0;
    rd(OFF_GB_STAT, 16'hA800);
    rd(OFF_GB_STAT, 16'h2800);
    @(posedge clk);
    idle_rx_send_n <= 1'b1;
    rx_error <= 1'b1;
    tick(3);
    @(posedge clk);
    rx_error <= 1'b0;
    tick(1);
    @(posedge clk);
    rx_error <= 1'b1;
    idle_rx_send_n <= 1'b0;
    tick(1);
    rd(OFF_GB_STAT, 16'h2803);
    rd(OFF_GB_STAT, 16'h2800);
    wr(OFF_GB_STAT, 16'hFFFF);
    rd(OFF_GB_STAT, 16'h2800);
    @(posedge clk);
    idle_rx_send_n <= 1'b1;
    tick(256);
    rd(OFF_GB_STAT, 16'h28FF);
    rd(OFF_GB_STAT, 16'h2800);
    $display("test status done");
    wr(OFF_EXT_WDATA, 16'hA5C3);
    wr(OFF_EXT_CTRL, 16'h815A);
    @(negedge clk);
    chk(16'(ext_stb), 16'h0001);
    chk(16'({ext_write, ext_addr}), 16'h035A);
    chk(ext_wdata, 16'hA5C3);
    wr(OFF_EXT_CTRL, 16'h7F5A);
    wr(OFF_EXT_RDATA, 16'hFFFF);
    rd(OFF_EXT_RDATA, 16'hA5C3);
    rd(OFF_EXT_CTRL, 16'h7F5A);
    wr(OFF_EXT_CTRL, 16'h005A);
    rd(OFF_EXT_RDATA, 16'h0000);
    $display("test extended done");
    end_sim;
  end
endmodule : gpr_regs_tb_top

`default_nettype wire
